// [rtl/counter_array_capture_compare.sv]
// Counter array: shared 16-bit counter, timebase, event flags, six modules.
// Assumes an APB master on pclk; pins arrive unsynchronised, timer0_overflow on pclk.
`timescale 1ns/1ns
module counter_array_capture_compare (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count sources and processor state
  input wire logic cpu_idle,
  input wire logic timer0_overflow,
  input wire logic ext_count_input,
  input wire logic ext_osc_div8,
  // Module pins and interrupt
  input wire logic [5:0] module_io_in,
  output logic [5:0] module_io_out,
  output logic [5:0] module_io_oe,
  output logic irq
);
  logic [15:0] count_reg;
  logic [7:0] snap_reg;
  logic [7:0] mode_reg;
  logic [7:0] width_reg;
  logic [7:0] flags_reg;
  cca_pkg::module_ctrl_t ctrl_reg [cca_pkg::NUM_MODULES];
  logic [3:0] presc_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_prev_reg;
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_prev_reg;
  logic [5:0] io_s1_reg;
  logic [5:0] io_s2_reg;
  logic step_reg;
  logic full_ovf_reg;
  logic part_ovf_reg;
  logic irq_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic tick;
  logic run;
  logic setup;
  logic acc_wr;
  logic cnt_wr;
  logic guard_on;
  logic rd_ok;
  logic [7:0] rd_data;
  logic [7:0] flags_next;
  logic [7:0] flags_clr;
  logic [7:0] irq_src;
  logic [15:0] part_mask;
  logic [15:0] mod_word;
  cca_pkg::timebase_t tb;
  cca_pkg::count_bus_t cbus;
  logic [15:0] ccr_w [cca_pkg::NUM_MODULES];
  logic [15:0] reload_w [cca_pkg::NUM_MODULES];
  logic [5:0] mod_event;
  logic [5:0] wr_low;
  logic [5:0] wr_high;
  logic [5:0] arsel;
  logic [5:0] mod_ien;
  logic [2:0] mod_idx;
  logic [3:0] mod_reg;
  logic mod_hit;
  logic hit_lo;
  logic hit_hi;
  logic hit_mode;
  logic hit_flags;
  logic hit_width;

  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pwrite && pready_reg;
  assign guard_on = mode_reg[cca_pkg::MODE_GUARD_EN];
  assign tb = cca_pkg::timebase_t'(mode_reg[cca_pkg::MODE_TB_LSB +: 3]);
  assign hit_lo = paddr == cca_pkg::OFF_COUNT_LOW;
  assign hit_hi = paddr == cca_pkg::OFF_COUNT_HIGH;
  assign hit_mode = paddr == cca_pkg::OFF_ARRAY_MODE;
  assign hit_flags = paddr == cca_pkg::OFF_FLAGS;
  assign hit_width = paddr == cca_pkg::OFF_WIDTH_CTRL;
  assign mod_reg = paddr[3:0];
  assign mod_idx = 3'(paddr[7:4] - cca_pkg::MOD_PAGE_FIRST);
  assign mod_hit = paddr[7:4] >= cca_pkg::MOD_PAGE_FIRST && paddr[7:4] < cca_pkg::MOD_PAGE_END
    && paddr[1:0] == 2'h0 && paddr[3:2] != 2'h3;
  assign cnt_wr = acc_wr && (hit_lo || hit_hi);
  assign part_mask = cca_pkg::width_mask(width_reg[1:0]);
  assign cbus = '{step: step_reg, full_ovf: full_ovf_reg, part_ovf: part_ovf_reg, value: count_reg};
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  // Read mux; reserved register bits read back as written, unmapped words read as zero
  always_comb
  begin
    rd_data = 8'h00;
    rd_ok = 1'b1;
    mod_word = arsel[mod_idx] ? reload_w[mod_idx] : ccr_w[mod_idx];
    if (hit_lo)
      rd_data = count_reg[7:0];
    else if (hit_hi)
      rd_data = snap_reg;
    else if (hit_mode)
      rd_data = mode_reg;
    else if (hit_flags)
      rd_data = flags_reg;
    else if (hit_width)
      rd_data = width_reg;
    else if (mod_hit)
    begin
      if (mod_reg == cca_pkg::OFF_MOD_CTRL)
        rd_data = ctrl_reg[mod_idx];
      else if (mod_reg == cca_pkg::OFF_MOD_CCR_LOW)
        rd_data = mod_word[7:0];
      else
        rd_data = mod_word[15:8];
    end
    else
      rd_ok = 1'b0;
  end

  // Zero-wait slave: read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      snap_reg <= 8'h00;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !rd_ok;
      if (setup && !pwrite)
        prdata_reg <= {24'h000000, rd_data};
      if (setup && !pwrite && hit_lo)
        snap_reg <= count_reg[15:8];
    end
  end

  // Pin synchronisers and edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      io_s1_reg <= 6'h00;
      io_s2_reg <= 6'h00;
    end
    else
    begin
      ext_s1_reg <= ext_count_input;
      ext_s2_reg <= ext_s1_reg;
      ext_prev_reg <= ext_s2_reg;
      osc_s1_reg <= ext_osc_div8;
      osc_s2_reg <= osc_s1_reg;
      osc_prev_reg <= osc_s2_reg;
      io_s1_reg <= module_io_in;
      io_s2_reg <= io_s1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_reg <= 4'h0;
    else if (presc_reg == cca_pkg::PRESCALE_LAST)
      presc_reg <= 4'h0;
    else
      presc_reg <= presc_reg + 4'h1;
  end

  always_comb
  begin
    case (tb)
      cca_pkg::TB_DIV12: tick = presc_reg == cca_pkg::PRESCALE_LAST;
      cca_pkg::TB_DIV4: tick = presc_reg[1:0] == cca_pkg::QUARTER_LAST;
      cca_pkg::TB_TIMER0: tick = timer0_overflow;
      cca_pkg::TB_EXT_EDGE: tick = ext_prev_reg && !ext_s2_reg;
      cca_pkg::TB_SYS: tick = 1'b1;
      cca_pkg::TB_OSC_DIV8: tick = osc_s2_reg && !osc_prev_reg;
      default: tick = 1'b0;
    endcase
  end

  assign run = tick && !(cpu_idle && mode_reg[cca_pkg::MODE_IDLE_SUSPEND]);

  // Counter; reads never touch it, software writes take priority
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= 16'h0000;
    else if (acc_wr && hit_lo)
      count_reg[7:0] <= pwdata[7:0];
    else if (acc_wr && hit_hi)
      count_reg[15:8] <= pwdata[7:0];
    else if (run)
      count_reg <= count_reg + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_reg <= 1'b0;
      full_ovf_reg <= 1'b0;
      part_ovf_reg <= 1'b0;
    end
    else
    begin
      step_reg <= run && !cnt_wr;
      full_ovf_reg <= run && !cnt_wr && count_reg == 16'hffff;
      part_ovf_reg <= run && !cnt_wr && (count_reg & part_mask) == part_mask;
    end
  end

  // Flags: software clears by writing zero, a same-cycle event wins
  assign flags_clr = (acc_wr && hit_flags) ? ~pwdata[7:0] : 8'h00;
  assign flags_next = (flags_reg & ~flags_clr) | {mod_event, part_ovf_reg, full_ovf_reg};
  assign irq_src = flags_reg & {mod_ien, width_reg[cca_pkg::WIDTH_POVF_IRQ_EN],
    mode_reg[cca_pkg::MODE_OVF_IRQ_EN]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_reg <= 8'h00;
      irq_reg <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      irq_reg <= |irq_src;
    end
  end

  // While the guard is on only the guard bit of the mode register changes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= cca_pkg::ARRAY_MODE_RESET;
    else if (acc_wr && hit_mode && guard_on)
      mode_reg[cca_pkg::MODE_GUARD_EN] <= pwdata[cca_pkg::MODE_GUARD_EN];
    else if (acc_wr && hit_mode)
      mode_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      width_reg <= cca_pkg::WIDTH_CTRL_RESET;
    else if (acc_wr && hit_width)
      width_reg <= pwdata[7:0];
  end

  for (genvar i = 0; i < cca_pkg::NUM_MODULES; i++)
  begin : g_mod
    logic sel;
    logic locked;
    assign sel = acc_wr && mod_hit && mod_idx == 3'(i);
    assign locked = guard_on && i == cca_pkg::GUARD_MODULE;
    assign wr_low[i] = sel && !locked && mod_reg == cca_pkg::OFF_MOD_CCR_LOW;
    assign wr_high[i] = sel && !locked && mod_reg == cca_pkg::OFF_MOD_CCR_HIGH;
    assign mod_ien[i] = ctrl_reg[i].irq_en;
    assign arsel[i] = width_reg[cca_pkg::WIDTH_ARSEL] && width_reg[1:0] != 2'h0
      && cca_pkg::decode_mode(ctrl_reg[i]) == cca_pkg::MODE_PWM_N;

    // Low byte write disarms the comparator, high byte write arms it
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        ctrl_reg[i] <= cca_pkg::module_ctrl_t'(cca_pkg::MOD_CTRL_RESET);
      else if (sel && !locked && mod_reg == cca_pkg::OFF_MOD_CTRL)
        ctrl_reg[i] <= cca_pkg::module_ctrl_t'(pwdata[7:0]);
      else if (wr_low[i])
        ctrl_reg[i].ecom <= 1'b0;
      else if (wr_high[i])
        ctrl_reg[i].ecom <= 1'b1;
    end

    capture_compare_unit u_unit (
      .pclk(pclk),
      .presetn(presetn),
      .cnt(cbus),
      .ctrl(ctrl_reg[i]),
      .width_sel(width_reg[1:0]),
      .wr_low(wr_low[i]),
      .wr_high(wr_high[i]),
      .to_reload(arsel[i]),
      .wdata(pwdata[7:0]),
      .io_in(io_s2_reg[i]),
      .ccr(ccr_w[i]),
      .reload(reload_w[i]),
      .event_pulse(mod_event[i]),
      .io_out(module_io_out[i]),
      .io_oe(module_io_oe[i])
    );
  end

  a_snapshot_latch: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_lo |=> snap_reg == $past(count_reg[15:8]) && prdata_reg[7:0] == $past(count_reg[7:0]))
    else $error("snapshot does not match counter at low byte read");
  a_read_no_stall: assert property (@(posedge pclk) disable iff (!presetn)
    run && !cnt_wr |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not advance on a tick");
  a_div12_rate: assert property (@(posedge pclk) disable iff (!presetn)
    tb == cca_pkg::TB_DIV12 && tick |=> (presc_reg != cca_pkg::PRESCALE_LAST) [*8] ##4 presc_reg == cca_pkg::PRESCALE_LAST)
    else $error("divide by twelve period wrong");
  a_ext_edge: assert property (@(posedge pclk) disable iff (!presetn)
    tb == cca_pkg::TB_EXT_EDGE && $past(ext_count_input, 3) && !$past(ext_count_input, 2) |-> tick)
    else $error("falling edge on external input not counted");
  a_osc_sync: assert property (@(posedge pclk) disable iff (!presetn)
    tb == cca_pkg::TB_OSC_DIV8 && tick |-> $past(ext_osc_div8, 2) && !$past(ext_osc_div8, 3))
    else $error("oscillator tick without synchronised rising edge");
  a_full_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
    run && !cnt_wr && count_reg == 16'hffff |=> count_reg == 16'h0000 ##1 flags_reg[cca_pkg::FLAG_FULL_OVF])
    else $error("wrap did not set overflow flag");
  a_ovf_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_reg[cca_pkg::MODE_OVF_IRQ_EN] && flags_reg[7:1] == 7'h00 |=> !irq_reg)
    else $error("overflow interrupt while disabled");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    flags_reg[cca_pkg::FLAG_FULL_OVF] && !(acc_wr && hit_flags) |=> flags_reg[cca_pkg::FLAG_FULL_OVF])
    else $error("overflow flag cleared without software write");
  a_idle_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_idle && mode_reg[cca_pkg::MODE_IDLE_SUSPEND] && !cnt_wr |=> $stable(count_reg))
    else $error("counter moved while suspended in idle");
  a_part_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
    run && !cnt_wr && (count_reg & part_mask) == part_mask |=> ##1 flags_reg[cca_pkg::FLAG_PART_OVF])
    else $error("partial wrap did not set flag");
  a_event_irq: assert property (@(posedge pclk) disable iff (!presetn)
    flags_reg[cca_pkg::FLAG_MOD_LSB] && ctrl_reg[0].irq_en |=> irq_reg)
    else $error("module event with enable raised no interrupt");
  a_guard_lock: assert property (@(posedge pclk) disable iff (!presetn)
    acc_wr && guard_on && mod_hit && mod_idx == 3'h5 && mod_reg == cca_pkg::OFF_MOD_CTRL |=> $stable(ctrl_reg[5]))
    else $error("guarded module written while guard on");
  c_full_wrap: cover property (@(posedge pclk) disable iff (!presetn) full_ovf_reg);
  c_guard_off: cover property (@(posedge pclk) disable iff (!presetn) $fell(guard_on));
  c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_reg));
endmodule : counter_array_capture_compare

// [rtl/cca_pkg.sv]
// Shared constants, types and decode helpers of the counter array block.
// Assumes 8-bit registers on word-aligned APB byte addresses, low byte lane.
package cca_pkg;
  localparam int NUM_MODULES = 6;
  localparam int GUARD_MODULE = 5;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFF_ARRAY_MODE = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_WIDTH_CTRL = 8'h10;
  // Module n page is 0x20 + 0x10 * n
  localparam logic [3:0] MOD_PAGE_FIRST = 4'h2;
  localparam logic [3:0] MOD_PAGE_END = 4'h8;
  localparam logic [3:0] OFF_MOD_CTRL = 4'h0;
  localparam logic [3:0] OFF_MOD_CCR_LOW = 4'h4;
  localparam logic [3:0] OFF_MOD_CCR_HIGH = 4'h8;
  localparam int MODE_IDLE_SUSPEND = 7;
  localparam int MODE_GUARD_EN = 6;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_OVF_IRQ_EN = 0;
  localparam int WIDTH_ARSEL = 7;
  localparam int WIDTH_POVF_IRQ_EN = 5;
  localparam int FLAG_FULL_OVF = 0;
  localparam int FLAG_PART_OVF = 1;
  localparam int FLAG_MOD_LSB = 2;
  localparam logic [7:0] ARRAY_MODE_RESET = 8'h40;
  localparam logic [7:0] WIDTH_CTRL_RESET = 8'h00;
  localparam logic [7:0] MOD_CTRL_RESET = 8'h00;
  localparam logic [3:0] PRESCALE_LAST = 4'hb;
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  typedef enum logic [2:0] {
    TB_DIV12 = 3'h0, TB_DIV4 = 3'h1, TB_TIMER0 = 3'h2, TB_EXT_EDGE = 3'h3,
    TB_SYS = 3'h4, TB_OSC_DIV8 = 3'h5
  } timebase_t;

  typedef enum logic [6:0] {
    MODE_OFF = 7'h01, MODE_CAPTURE = 7'h02, MODE_SWTIMER = 7'h04, MODE_HSO = 7'h08,
    MODE_FREQ = 7'h10, MODE_PWM_N = 7'h20, MODE_PWM16 = 7'h40
  } mode_t;

  typedef struct packed {
    logic pwm16;
    logic ecom;
    logic capp;
    logic capn;
    logic mat;
    logic tog;
    logic pwm;
    logic irq_en;
  } module_ctrl_t;

  typedef struct packed {
    logic step;
    logic full_ovf;
    logic part_ovf;
    logic [15:0] value;
  } count_bus_t;

  function automatic mode_t decode_mode(input module_ctrl_t c);
    if (c.pwm && !c.capp && !c.capn && !c.tog)
      return c.pwm16 ? MODE_PWM16 : MODE_PWM_N;
    if (c.pwm && c.tog && !c.capn && !c.mat)
      return MODE_FREQ;
    if (c.mat && !c.pwm && !c.capp && !c.capn)
      return c.tog ? MODE_HSO : MODE_SWTIMER;
    if (!c.mat && !c.tog && !c.pwm && (c.capp || c.capn))
      return MODE_CAPTURE;
    return MODE_OFF;
  endfunction : decode_mode

  function automatic logic [15:0] width_mask(input logic [1:0] sel);
    case (sel)
      2'h0: return 16'h00ff;
      2'h1: return 16'h01ff;
      2'h2: return 16'h03ff;
      default: return 16'h07ff;
    endcase
  endfunction : width_mask
endpackage : cca_pkg

// [rtl/capture_compare_unit.sv]
// One capture/compare module working against the shared counter.
// Assumes io_in is already synchronised and the cnt step and overflow fields are one-cycle pulses.
`timescale 1ns/1ns
module capture_compare_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Shared counter and configuration
  input wire cca_pkg::count_bus_t cnt,
  input wire cca_pkg::module_ctrl_t ctrl,
  input wire logic [1:0] width_sel,
  // Register writes
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic to_reload,
  input wire logic [7:0] wdata,
  // Pin and results
  input wire logic io_in,
  output logic [15:0] ccr,
  output logic [15:0] reload,
  output logic event_pulse,
  output logic io_out,
  output logic io_oe
);
  cca_pkg::mode_t mode;
  logic [15:0] ccr_reg;
  logic [15:0] reload_reg;
  logic [15:0] mask;
  logic io_prev_reg;
  logic io_out_reg;
  logic io_oe_reg;
  logic event_reg;
  logic full_hit;
  logic part_hit;
  logic low_hit;
  logic edge_hit;

  assign mode = cca_pkg::decode_mode(ctrl);
  assign mask = cca_pkg::width_mask(width_sel);
  // Comparator only runs with ecom set
  assign full_hit = cnt.step && ctrl.ecom && cnt.value == ccr_reg;
  assign part_hit = cnt.step && ctrl.ecom && ((cnt.value ^ ccr_reg) & mask) == 16'h0000;
  assign low_hit = cnt.step && ctrl.ecom && cnt.value[7:0] == ccr_reg[7:0];
  assign edge_hit = (ctrl.capp && io_in && !io_prev_reg) || (ctrl.capn && !io_in && io_prev_reg);
  assign ccr = ccr_reg;
  assign reload = reload_reg;
  assign event_pulse = event_reg;
  assign io_out = io_out_reg;
  assign io_oe = io_oe_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ccr_reg <= 16'h0000;
    else if (wr_low && !to_reload)
      ccr_reg[7:0] <= wdata;
    else if (wr_high && !to_reload)
      ccr_reg[15:8] <= wdata;
    else
      case (mode)
        cca_pkg::MODE_CAPTURE: if (edge_hit) ccr_reg <= cnt.value;
        cca_pkg::MODE_FREQ: if (low_hit) ccr_reg[7:0] <= ccr_reg[7:0] + ccr_reg[15:8];
        cca_pkg::MODE_PWM_N:
          if (cnt.part_ovf)
          begin
            if (width_sel == 2'h0)
              ccr_reg[7:0] <= ccr_reg[15:8];
            else
              ccr_reg <= reload_reg;
          end
        default: ccr_reg <= ccr_reg;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_reg <= 16'h0000;
    else if (wr_low && to_reload)
      reload_reg[7:0] <= wdata;
    else if (wr_high && to_reload)
      reload_reg[15:8] <= wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_prev_reg <= 1'b0;
      event_reg <= 1'b0;
    end
    else
    begin
      io_prev_reg <= io_in;
      case (mode)
        cca_pkg::MODE_CAPTURE: event_reg <= edge_hit;
        cca_pkg::MODE_SWTIMER, cca_pkg::MODE_HSO: event_reg <= full_hit;
        cca_pkg::MODE_PWM_N: event_reg <= part_hit && ctrl.mat;
        cca_pkg::MODE_PWM16: event_reg <= full_hit && ctrl.mat;
        default: event_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_out_reg <= 1'b0;
      io_oe_reg <= 1'b0;
    end
    else
    begin
      io_oe_reg <= mode inside {cca_pkg::MODE_HSO, cca_pkg::MODE_FREQ, cca_pkg::MODE_PWM_N, cca_pkg::MODE_PWM16};
      case (mode)
        cca_pkg::MODE_HSO: io_out_reg <= io_out_reg ^ full_hit;
        cca_pkg::MODE_FREQ: io_out_reg <= io_out_reg ^ low_hit;
        cca_pkg::MODE_PWM_N:
          if (!ctrl.ecom || (cnt.part_ovf && !part_hit))
            io_out_reg <= 1'b0;
          else if (part_hit)
            io_out_reg <= 1'b1;
        cca_pkg::MODE_PWM16:
          if (!ctrl.ecom || (cnt.full_ovf && !full_hit))
            io_out_reg <= 1'b0;
          else if (full_hit)
            io_out_reg <= 1'b1;
        default: io_out_reg <= io_out_reg;
      endcase
    end
  end

  a_capture_load: assert property (@(posedge pclk) disable iff (!presetn)
    mode == cca_pkg::MODE_CAPTURE && edge_hit && !wr_low && !wr_high
    |=> ccr_reg == $past(cnt.value) && event_reg)
    else $error("capture did not load counter and flag");
  a_pwm_off_low: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == cca_pkg::MODE_PWM_N || mode == cca_pkg::MODE_PWM16) && !ctrl.ecom |=> !io_out_reg)
    else $error("pwm output high with comparator off");
  c_pwm_cycle: cover property (@(posedge pclk) disable iff (!presetn)
    mode == cca_pkg::MODE_PWM_N && $rose(io_out_reg));
endmodule : capture_compare_unit

// [dv/apb_host.sv]
// APB master model standing in for the processor core.
// Assumes the slave answers with pready; waits with no cycle count of its own.
`timescale 1ns/1ns
module apb_host (
  // Bus
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : apb_host

// [dv/tb.sv]
// Self-checking bench of the counter array block.
// Assumes the APB host model in apb_host.sv drives the bus.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, err;
  logic cpu_idle = 1'b1;
  logic ext_in = 1'b1;
  logic osc_in = 1'b0;
  logic [5:0] io_in = 6'h00;
  logic [5:0] io_out, io_oe;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #50 pclk = ~pclk;
  apb_host i_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  counter_array_capture_compare i_counter_array_capture_compare (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .timer0_overflow(1'b0),
    .ext_count_input(ext_in), .ext_osc_div8(osc_in), .module_io_in(io_in), .module_io_out(io_out),
    .module_io_oe(io_oe), .irq(irq));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_apb_host.xfer(1'b1, a, d, q, err);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_apb_host.xfer(1'b0, a, 8'h00, q, err);
  endtask : rd
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic t_reset();
    rd(cca_pkg::OFF_ARRAY_MODE);
    `CHK(q, cca_pkg::ARRAY_MODE_RESET)
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h4d);
    rd(cca_pkg::OFF_ARRAY_MODE);
    `CHK(q, cca_pkg::ARRAY_MODE_RESET)
    wr(8'h70, 8'h42);
    rd(8'h70);
    `CHK(q, 8'h00)
    rd(8'hf0);
    `CHK({err, q}, 9'h100)
    $display("test reset done");
  endtask : t_reset
  task automatic t_overflow();
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h00);
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h0c);
    wr(cca_pkg::OFF_COUNT_HIGH, 8'hff);
    wr(cca_pkg::OFF_COUNT_LOW, 8'hfe);
    rd(cca_pkg::OFF_COUNT_LOW);
    `CHK(q, 8'hfe)
    rd(cca_pkg::OFF_COUNT_HIGH);
    `CHK(q, 8'hff)
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h08);
    repeat (8) @(posedge pclk);
    rd(cca_pkg::OFF_FLAGS);
    `CHK(q[1:0], 2'h3)
    `CHK(irq, 1'b0)
    rd(cca_pkg::OFF_COUNT_LOW);
    `CHK(q > 8'h04, 1'b1)
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h09);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(cca_pkg::OFF_FLAGS, 8'hfe);
    rd(cca_pkg::OFF_FLAGS);
    `CHK(q[0], 1'b0)
    $display("test overflow done");
  endtask : t_overflow
  task automatic t_capture();
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h0c);
    wr(cca_pkg::OFF_COUNT_HIGH, 8'h12);
    wr(cca_pkg::OFF_COUNT_LOW, 8'h34);
    wr(8'h20, 8'h20);
    io_in <= 6'h01;
    repeat (8) @(posedge pclk);
    rd(8'h24);
    `CHK(q, 8'h34)
    rd(8'h28);
    `CHK(q, 8'h12)
    rd(cca_pkg::OFF_FLAGS);
    `CHK(q[2], 1'b1)
    $display("test capture done");
  endtask : t_capture
  // Pin edges held four clocks per level; idle suspend freezes the count
  task automatic t_ext();
    wr(cca_pkg::OFF_COUNT_LOW, 8'h00);
    wr(cca_pkg::OFF_COUNT_HIGH, 8'h00);
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h06);
    for (int k = 0; k < 5; k++)
    begin
      if (k == 3)
        wr(cca_pkg::OFF_ARRAY_MODE, 8'h86);
      if (k == 4)
        wr(cca_pkg::OFF_ARRAY_MODE, 8'h0a);
      ext_in <= 1'b0;
      osc_in <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_in <= 1'b1;
      osc_in <= 1'b0;
      repeat (4) @(posedge pclk);
      if (k >= 2)
      begin
        rd(cca_pkg::OFF_COUNT_LOW);
        `CHK(q, (k == 4) ? 8'h04 : 8'h03)
      end
    end
    $display("test ext done");
  endtask : t_ext
  task automatic t_pwm();
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h0c);
    wr(8'h30, 8'h82);
    repeat (2) @(posedge pclk);
    `CHK({io_oe[1], io_out[1]}, 2'h2)
    wr(cca_pkg::OFF_COUNT_HIGH, 8'hff);
    wr(cca_pkg::OFF_COUNT_LOW, 8'hff);
    wr(8'h34, 8'h00);
    wr(8'h38, 8'h00);
    wr(cca_pkg::OFF_ARRAY_MODE, 8'h08);
    repeat (4) @(posedge pclk);
    `CHK({io_oe[1], io_out[1]}, 2'h3)
    $display("test pwm done");
  endtask : t_pwm
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_overflow();
    t_capture();
    t_ext();
    t_pwm();
    summarize();
  end
endmodule : tb
